// ### src/css_pkg.sv
// Shared constants and types for the charge state sequencer
package css_pkg;

    // Register byte offsets on the APB port
    localparam logic [7:0] CSS_ADDR_CONTROL_ONE = 8'h00;
    localparam logic [7:0] CSS_ADDR_BAT_CURRENT = 8'h04;
    localparam logic [7:0] CSS_ADDR_CHG_VOLTAGE = 8'h08;
    localparam logic [7:0] CSS_ADDR_INPUT_LIMIT = 8'h0c;
    localparam logic [7:0] CSS_ADDR_STATUS      = 8'h10;
    localparam logic [7:0] CSS_ADDR_APPLIED     = 8'h14;

    // control_one field positions
    localparam int CSS_BIT_CHARGE_RUN = 0;
    localparam int CSS_BIT_THERM_ON   = 1;
    localparam int CSS_BIT_REG_RESET  = 2;
    localparam int CSS_BIT_SW_THRESH  = 3;
    localparam int CSS_BIT_WD_ENABLE  = 4;

    // battery_current_setting field positions
    localparam int CSS_LSB_CHG_CODE = 0;
    localparam int CSS_LSB_END_CODE = 4;

    // applied-value readback field positions
    localparam int CSS_LSB_APP_VOLT = 4;
    localparam int CSS_LSB_APP_INLIM = 12;

    // status field positions
    localparam int CSS_LSB_STATE      = 0;
    localparam int CSS_BIT_THERM_PRES = 11;
    localparam int CSS_BIT_SW_PRES    = 12;
    localparam int CSS_BIT_CV_MODE    = 13;
    localparam int CSS_BIT_WD_EXPIRED = 14;

    // Reset values of the programmable registers
    localparam logic [4:0] CSS_RST_CONTROL_ONE = 5'h13;
    localparam logic [3:0] CSS_RST_CHG_CODE    = 4'h0;
    localparam logic [2:0] CSS_RST_END_CODE    = 3'h0;
    localparam logic [5:0] CSS_RST_CHG_VOLTAGE = 6'h00;
    localparam logic [3:0] CSS_RST_INPUT_LIMIT = 4'h0;

    // Timing: one ramp step per interval
    localparam int CSS_CLK_MHZ      = 250;
    localparam int CSS_STEP_TIME_US = 10;
    localparam int CSS_STEP_CYCLES  = CSS_STEP_TIME_US * CSS_CLK_MHZ;
    localparam int CSS_CONFIG_CYCLES = 64;

    // Charge states, one-hot
    typedef enum logic [10:0] {
        CSS_OFF       = 11'h001,
        CSS_CONFIG    = 11'h002,
        CSS_WAIT      = 11'h004,
        CSS_SAFE      = 11'h008,
        CSS_PRE       = 11'h010,
        CSS_FULL      = 11'h020,
        CSS_END       = 11'h040,
        CSS_FAULT     = 11'h080,
        CSS_WEAK_WAIT = 11'h100,
        CSS_WEAK_SAFE = 11'h200,
        CSS_WEAK_CHG  = 11'h400
    } css_state_type;

    // Current source selection for the analogue current loop
    typedef enum logic [1:0] {
        CSS_CUR_NONE = 2'h0,
        CSS_CUR_SAFE = 2'h1,
        CSS_CUR_PRE  = 2'h2,
        CSS_CUR_PROG = 2'h3
    } css_cur_type;

    // Analogue comparator outputs, asynchronous to mclk
    typedef struct packed {
        logic inAboveDetect;
        logic inAboveBatMargin;
        logic batAboveSafe;
        logic batAbovePre;
        logic batAboveRecharge;
        logic batNearChargeVoltage;
        logic currentBelowEnd;
        logic batAboveSwitch;
        logic switchProbeHigh;
        logic thermistorSensed;
        logic tempGood;
        logic hostPowerMode;
    } css_sense_type;

    // Controls toward the analogue power stage
    typedef struct packed {
        logic        converterOn;
        logic        constantVoltage;
        logic        linearSourceOn;
        css_cur_type currentSelect;
        logic        thermistorBlockOn;
        logic        switchThresholdSelect;
        logic [3:0]  chargeCurrentCode;
        logic [2:0]  endCurrentCode;
        logic [5:0]  chargeVoltageCode;
        logic [3:0]  inputLimitCode;
    } css_power_type;

endpackage

// ### src/css_sequencer.sv
// Charge state sequencer with APB register port
`timescale 1ns/1ps

module css_sequencer
    import css_pkg::*;
#(
    parameter int WD_CYCLES = 250000000
) (
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic               pready,
    output logic [31:0]        prdata,
    output logic               pslverr,
    input  wire css_sense_type sense,
    output css_power_type      power,
    output logic               switchDrive,
    output logic               switchProbe,
    output logic               thermistorPresent,
    output logic               switchPresent
);

    // Bring a code one step closer to its target
    function automatic logic [5:0] stepToward(input logic [5:0] cur,
                                              input logic [5:0] tgt);
        if (cur < tgt) begin
            return 6'(cur + 6'h01);
        end else if (cur > tgt) begin
            return 6'(cur - 6'h01);
        end else begin
            return cur;
        end
    endfunction

    css_sense_type senseMeta;
    css_sense_type senseSync;
    css_state_type state;
    css_state_type next_state;
    logic [4:0]  controlOne;
    logic [3:0]  chargeCurrentCode;
    logic [2:0]  endCurrentCode;
    logic [5:0]  chargeVoltageCode;
    logic [3:0]  inputLimitCode;
    logic [3:0]  appliedCurrent;
    logic [5:0]  appliedVoltage;
    logic [3:0]  appliedLimit;
    logic [11:0] stepCount;
    logic        stepTick;
    logic [6:0]  configCount;
    logic [31:0] wdCount;
    logic        wdExpired;
    logic        stackReset;
    logic        redetect;
    logic        setupPhase;
    logic        writeAccess;
    logic        chargeRun;
    logic        inputValid;
    assign setupPhase  = psel && !penable;
    assign writeAccess = psel && penable && pwrite;
    assign chargeRun   = controlOne[CSS_BIT_CHARGE_RUN];
    always_ff @(posedge mclk) begin
        if (rst) begin
            senseMeta <= '0;
            senseSync <= '0;
        end else begin
            senseMeta <= sense;
            senseSync <= senseMeta;
        end
    end
    // input valid and above battery by margin
    assign inputValid = senseSync.inAboveDetect && senseSync.inAboveBatMargin;
    // Zero-wait-state slave; read data is captured in the setup cycle
    assign pready = 1'b1;
    always_ff @(posedge mclk) begin
        if (rst) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (setupPhase) begin
            pslverr <= 1'b0;
            prdata  <= '0;
            if (paddr == CSS_ADDR_CONTROL_ONE) begin
                prdata[4:0] <= controlOne;
            end else if (paddr == CSS_ADDR_BAT_CURRENT) begin
                prdata[CSS_LSB_CHG_CODE +: 4] <= chargeCurrentCode;
                prdata[CSS_LSB_END_CODE +: 3] <= endCurrentCode;
            end else if (paddr == CSS_ADDR_CHG_VOLTAGE) begin
                prdata[5:0] <= chargeVoltageCode;
            end else if (paddr == CSS_ADDR_INPUT_LIMIT) begin
                prdata[3:0] <= inputLimitCode;
            end else if (paddr == CSS_ADDR_STATUS) begin
                prdata[CSS_LSB_STATE +: 11]  <= state;
                prdata[CSS_BIT_THERM_PRES]   <= thermistorPresent;
                prdata[CSS_BIT_SW_PRES]      <= switchPresent;
                prdata[CSS_BIT_CV_MODE]      <= power.constantVoltage;
                prdata[CSS_BIT_WD_EXPIRED]   <= wdExpired;
            end else if (paddr == CSS_ADDR_APPLIED) begin
                prdata[3:0]                  <= appliedCurrent;
                prdata[CSS_LSB_APP_VOLT +: 6] <= appliedVoltage;
                prdata[CSS_LSB_APP_INLIM +: 4] <= appliedLimit;
            end else begin
                pslverr <= 1'b1;
            end
        end
    end
    // stack reset is a one-cycle strobe, the bit never reads back
    always_ff @(posedge mclk) begin
        if (rst) begin
            stackReset <= 1'b0;
        end else begin
            stackReset <= writeAccess && paddr == CSS_ADDR_CONTROL_ONE
                          && pwdata[CSS_BIT_REG_RESET];
        end
    end
    // writes land at any time; control and end-current codes act directly, current, voltage and limit codes ramp
    always_ff @(posedge mclk) begin
        if (rst || stackReset) begin
            controlOne        <= CSS_RST_CONTROL_ONE;
            chargeCurrentCode <= CSS_RST_CHG_CODE;
            endCurrentCode    <= CSS_RST_END_CODE;
            chargeVoltageCode <= CSS_RST_CHG_VOLTAGE;
            inputLimitCode    <= CSS_RST_INPUT_LIMIT;
        end else if (writeAccess) begin
            if (paddr == CSS_ADDR_CONTROL_ONE) begin
                controlOne <= pwdata[4:0] & ~(5'h01 << CSS_BIT_REG_RESET);
            end else if (paddr == CSS_ADDR_BAT_CURRENT) begin
                chargeCurrentCode <= pwdata[CSS_LSB_CHG_CODE +: 4];
                endCurrentCode    <= pwdata[CSS_LSB_END_CODE +: 3];
            end else if (paddr == CSS_ADDR_CHG_VOLTAGE) begin
                chargeVoltageCode <= pwdata[5:0];
            end else if (paddr == CSS_ADDR_INPUT_LIMIT) begin
                inputLimitCode <= pwdata[3:0];
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (rst || stepTick) begin
            stepCount <= '0;
        end else begin
            stepCount <= 12'(stepCount + 12'h001);
        end
    end
    assign stepTick = stepCount == 12'(CSS_STEP_CYCLES - 1);
    // applied targets walk one code per interval
    always_ff @(posedge mclk) begin
        if (rst) begin
            appliedCurrent <= CSS_RST_CHG_CODE;
            appliedVoltage <= CSS_RST_CHG_VOLTAGE;
            appliedLimit   <= CSS_RST_INPUT_LIMIT;
        end else if (stepTick) begin
            appliedCurrent <= 4'(stepToward({2'h0, appliedCurrent},
                                            {2'h0, chargeCurrentCode}));
            appliedVoltage <= stepToward(appliedVoltage, chargeVoltageCode);
            appliedLimit   <= 4'(stepToward({2'h0, appliedLimit},
                                            {2'h0, inputLimitCode}));
        end
    end
    // any write restarts the watchdog; expiry sticks until a write
    always_ff @(posedge mclk) begin
        if (rst) begin
            wdCount   <= '0;
            wdExpired <= 1'b0;
        end else if (writeAccess) begin
            wdCount   <= '0;
            wdExpired <= 1'b0;
        end else if (controlOne[CSS_BIT_WD_ENABLE] && state != CSS_OFF
                     && !wdExpired) begin
            if (wdCount == 32'(WD_CYCLES - 1)) begin
                wdExpired <= 1'b1;
            end else begin
                wdCount <= 32'(wdCount + 32'h1);
            end
        end
    end
    // stack reset forces fresh detection; set beats clear
    always_ff @(posedge mclk) begin
        if (rst || (state == CSS_CONFIG && !stackReset)) begin
            redetect <= 1'b0;
        end else if (stackReset) begin
            redetect <= 1'b1;
        end
    end
    // Probe settle time in config state
    always_ff @(posedge mclk) begin
        if (rst || state != CSS_CONFIG) begin
            configCount <= '0;
        end else begin
            configCount <= 7'(configCount + 7'h01);
        end
    end
    // presence recorded at the end of config
    always_ff @(posedge mclk) begin
        if (rst) begin
            thermistorPresent <= 1'b0;
            switchPresent     <= 1'b0;
        end else if (state == CSS_OFF) begin
            thermistorPresent <= 1'b0;
            switchPresent     <= 1'b0;
        end else if (state == CSS_CONFIG
                     && configCount == 7'(CSS_CONFIG_CYCLES - 1)) begin
            switchPresent     <= senseSync.switchProbeHigh;
            thermistorPresent <= senseSync.thermistorSensed;
        end
    end
    always_comb begin
        next_state = state;
        case (state)
            CSS_OFF: begin
                if (inputValid) begin
                    next_state = CSS_CONFIG;
                end
            end
            CSS_CONFIG: begin
                if (configCount == 7'(CSS_CONFIG_CYCLES - 1)) begin
                    next_state = CSS_WAIT;
                end
            end
            CSS_WAIT: begin
                if (switchPresent && !senseSync.batAboveSwitch
                    && !senseSync.hostPowerMode) begin
                    next_state = CSS_WEAK_WAIT;
                end else begin
                    next_state = CSS_SAFE;
                end
            end
            CSS_SAFE: begin
                if (senseSync.batAboveSafe) begin
                    next_state = CSS_PRE;
                end
            end
            CSS_PRE: begin
                if (senseSync.batAbovePre) begin
                    next_state = CSS_FULL;
                end
            end
            CSS_FULL: begin
                if (senseSync.batAboveRecharge && senseSync.currentBelowEnd) begin
                    next_state = CSS_END;
                end
            end
            CSS_END: begin
                if (!senseSync.batAboveRecharge) begin
                    next_state = CSS_FULL;
                end
            end
            CSS_FAULT: begin
                if (chargeRun && !wdExpired) begin
                    next_state = CSS_WAIT;
                end
            end
            CSS_WEAK_WAIT: begin
                // temperature fine or no thermistor; else stay
                if (senseSync.tempGood || !thermistorPresent) begin
                    next_state = CSS_WEAK_SAFE;
                end
            end
            CSS_WEAK_SAFE: begin
                if (senseSync.batAboveSafe) begin
                    next_state = CSS_WEAK_CHG;
                end
            end
            CSS_WEAK_CHG: begin
                if (senseSync.batAboveSwitch) begin
                    next_state = CSS_FULL;
                end
            end
            default: begin
                next_state = CSS_OFF;
            end
        endcase
        // Unplug wins over everything, then re-detection, then fault
        if (!inputValid) begin
            next_state = CSS_OFF;
        end else if (state != CSS_OFF && redetect) begin
            next_state = CSS_CONFIG;
        end else if (state != CSS_OFF && state != CSS_CONFIG
                     && (!chargeRun || wdExpired)) begin
            next_state = CSS_FAULT;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= CSS_OFF;
        end else begin
            state <= next_state;
        end
    end
    // probe raises the pin only while detecting
    always_ff @(posedge mclk) begin
        if (rst) begin
            switchProbe <= 1'b0;
        end else begin
            switchProbe <= next_state == CSS_CONFIG;
        end
    end

    // switch open only in the weak-battery states
    // never open above the switch threshold
    always_ff @(posedge mclk) begin
        if (rst) begin
            switchDrive <= 1'b0;
        end else begin
            switchDrive <= switchPresent && !senseSync.batAboveSwitch
                           && (state == CSS_WEAK_WAIT
                               || state == CSS_WEAK_SAFE
                               || state == CSS_WEAK_CHG);
        end
    end

    // Power stage controls, registered so the pins never glitch
    always_ff @(posedge mclk) begin
        if (rst) begin
            power <= '0;
        end else begin
            // converter runs in pre, full and weak states
            power.converterOn <= state == CSS_PRE || state == CSS_FULL
                                 || state == CSS_WEAK_WAIT
                                 || state == CSS_WEAK_SAFE
                                 || state == CSS_WEAK_CHG;
            // voltage loop takes over near the target in full, and always in weak wait
            power.constantVoltage <= (state == CSS_FULL
                                      && senseSync.batNearChargeVoltage)
                                     || state == CSS_WEAK_WAIT;
            power.linearSourceOn <= state == CSS_SAFE
                                    || state == CSS_WEAK_SAFE
                                    || state == CSS_WEAK_CHG;
            if (state == CSS_SAFE || state == CSS_WEAK_SAFE) begin
                power.currentSelect <= CSS_CUR_SAFE;
            end else if (state == CSS_PRE) begin
                power.currentSelect <= CSS_CUR_PRE;
            end else if (state == CSS_FULL) begin
                power.currentSelect <= CSS_CUR_PROG;
            end else begin
                // end of charge halts battery current
                power.currentSelect <= CSS_CUR_NONE;
            end
            // only the fault state honours the power-down bit
            power.thermistorBlockOn <= state != CSS_FAULT
                                       || controlOne[CSS_BIT_THERM_ON];
            power.switchThresholdSelect <= controlOne[CSS_BIT_SW_THRESH];
            power.chargeCurrentCode <= appliedCurrent;
            power.endCurrentCode    <= endCurrentCode;
            power.chargeVoltageCode <= appliedVoltage;
            power.inputLimitCode    <= appliedLimit;
        end
    end

endmodule

// ### tb/css_sequencer_props.sv
// Port-level assertion checker for the charge state sequencer
`timescale 1ns/1ps
module css_sequencer_props
    import css_pkg::*;
#(
    parameter int WD_CYCLES = 250000000
) (
    input wire logic          mclk,
    input wire logic          rst,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [7:0]    paddr,
    input wire logic [31:0]   pwdata,
    input wire logic          pready,
    input wire logic [31:0]   prdata,
    input wire logic          pslverr,
    input wire css_sense_type sense,
    input wire css_power_type power,
    input wire logic          switchDrive,
    input wire logic          switchProbe,
    input wire logic          thermistorPresent,
    input wire logic          switchPresent
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_NO_INPUT: assert property ((!sense.inAboveDetect) [*6] |->
        !switchProbe && !power.converterOn && power.currentSelect == CSS_CUR_NONE)
        else $error("active outputs without a valid input");
    AST_RUN_OFF: assert property (psel && penable && pwrite && paddr == 8'h00
        && !pwdata[0] && !pwdata[2] |-> ##[1:4] power.currentSelect == CSS_CUR_NONE)
        else $error("charging not suspended after run bit cleared");
    AST_STACK_RESET: assert property (psel && penable && pwrite
        && paddr == 8'h00 && pwdata[2] |-> ##3
        power.thermistorBlockOn && !power.switchThresholdSelect)
        else $error("defaults not restored by stack reset");
    AST_SAFE: assert property (power.currentSelect == CSS_CUR_SAFE && !switchDrive
        |-> power.linearSourceOn && !power.converterOn)
        else $error("safe current without linear source");
    AST_PRE: assert property (power.currentSelect == CSS_CUR_PRE |-> power.converterOn)
        else $error("pre-charge current with converter off");
    AST_CV: assert property (power.constantVoltage |-> power.converterOn)
        else $error("voltage regulation with converter off");
    AST_ABOVE_SW: assert property (sense.batAboveSwitch [*6] |-> !switchDrive)
        else $error("switch open above switch threshold");
    AST_DETECT: assert property ($rose(switchPresent)
        |-> $past(switchProbe) || $past(switchProbe, 2))
        else $error("switch presence set outside detection");
    AST_WEAK: assert property (switchDrive |-> power.converterOn && switchPresent)
        else $error("switch opened without converter or switch");
    AST_MAPPED: assert property (psel && !penable && paddr <= 8'h14
        && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("error on a mapped register");
    AST_UNMAPPED: assert property (psel && !penable && paddr > 8'h14
        |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_READY: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
endmodule

bind css_sequencer css_sequencer_props #(.WD_CYCLES(WD_CYCLES)) props_inst (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .sense(sense), .power(power),
    .switchDrive(switchDrive), .switchProbe(switchProbe),
    .thermistorPresent(thermistorPresent), .switchPresent(switchPresent));

// ### tb/css_switch_model.sv
// Model of the battery switch pin as seen by the presence probe
`timescale 1ns/1ps
module css_switch_model (
    input  wire logic mclk,
    input  wire logic switchProbe,
    input  wire logic switchDrive,
    input  wire logic fitted,
    output logic      probeHigh
);
    // Without a switch the pin is tied to ground, so the probe cannot lift it
    always_ff @(posedge mclk) begin
        probeHigh <= switchProbe && fitted && !switchDrive;
    end
endmodule

// ### tb/test_css_sequencer.sv
// Self-checking bench for the charge state sequencer
`timescale 1ns/1ps
module test_css_sequencer import css_pkg::*;;
    localparam int WD = 8000;
    logic          mclk, rst, psel, penable, pwrite, pready, pslverr, e;
    logic          fitted, probeHigh, switchDrive, switchProbe, swPres, thPres;
    logic [7:0]    paddr;
    logic [31:0]   pwdata, prdata, q;
    css_sense_type s, senseTb, sense;
    css_power_type power;
    int            mismatches, cmpCount, cycles;

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always_comb begin
        sense = senseTb;
        sense.switchProbeHigh = probeHigh;
    end

    css_sequencer #(.WD_CYCLES(WD)) css_sequencer_inst (.mclk(mclk),
        .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .sense(sense), .power(power),
        .switchDrive(switchDrive), .switchProbe(switchProbe),
        .thermistorPresent(thPres), .switchPresent(swPres));
    css_switch_model css_switch_model_inst (.mclk(mclk),
        .switchProbe(switchProbe), .switchDrive(switchDrive),
        .fitted(fitted), .probeHigh(probeHigh));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmpCount, mismatches);
        if (mismatches == 0 && cmpCount > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // A hung wait ends here as a mismatch
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0);
        chk(q, x);
    endtask
    task automatic st(input logic [10:0] x);
        bus(1'b0, CSS_ADDR_STATUS, 32'h0);
        chk({21'h0, q[10:0]}, {21'h0, x});
    endtask
    // Comparators settle through two sync stages, so ten cycles is ample
    task automatic apply();
        @(posedge mclk);
        senseTb <= s;
        repeat (10) @(posedge mclk);
    endtask
    task automatic done(input string n);
        $display("test %s finished", n);
    endtask

    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {s, senseTb, fitted, mismatches, cmpCount, cycles} = '0;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        rd(CSS_ADDR_CONTROL_ONE, 32'h13);
        bus(1'b0, 8'h18, 32'h0);
        chk({31'h0, e}, 32'h1);
        done("defaults");
        fitted <= 1'b1;
        {s.thermistorSensed, s.inAboveDetect, s.inAboveBatMargin} = 3'h7;
        apply();
        repeat (80) @(posedge mclk);
        st(11'h100);
        chk({29'h0, thPres, q[12:11]}, 32'h7);
        chk({31'h0, switchDrive}, 32'h1);
        chk({30'h0, power.converterOn, power.linearSourceOn}, 32'h2);
        repeat (100) @(posedge mclk);
        st(11'h100);
        s.tempGood = 1'b1;
        apply();
        st(11'h200);
        s.batAboveSafe = 1'b1;
        apply();
        st(11'h400);
        s.batAboveSwitch = 1'b1;
        apply();
        st(11'h020);
        chk({31'h0, switchDrive}, 32'h0);
        chk({30'h0, power.currentSelect}, 32'h3);
        done("weak path");
        s.batNearChargeVoltage = 1'b1;
        apply();
        bus(1'b0, CSS_ADDR_STATUS, 32'h0);
        chk({31'h0, q[13]}, 32'h1);
        {s.batAboveRecharge, s.currentBelowEnd} = 2'h3;
        apply();
        st(11'h040);
        chk({30'h0, power.currentSelect}, 32'h0);
        s.batAboveRecharge = 1'b0;
        apply();
        st(11'h020);
        done("charge end");
        bus(1'b1, CSS_ADDR_CHG_VOLTAGE, 32'h1);
        bus(1'b1, CSS_ADDR_INPUT_LIMIT, 32'h1);
        bus(1'b1, CSS_ADDR_BAT_CURRENT, 32'h32);
        repeat (100) @(posedge mclk);
        bus(1'b0, CSS_ADDR_APPLIED, 32'h0);
        chk({31'h0, q[3:0] == 4'h2}, 32'h0);
        repeat (5200) @(posedge mclk);
        bus(1'b0, CSS_ADDR_APPLIED, 32'h0);
        chk({18'h0, q[15:12], q[9:4], q[3:0]}, 32'h412);
        chk({15'h0, power.inputLimitCode, power.chargeVoltageCode,
            power.endCurrentCode, power.chargeCurrentCode}, 32'h20b2);
        st(11'h020);
        done("ramp");
        bus(1'b1, CSS_ADDR_CONTROL_ONE, 32'h12);
        repeat (10) @(posedge mclk);
        st(11'h080);
        bus(1'b1, CSS_ADDR_CONTROL_ONE, 32'h10);
        repeat (10) @(posedge mclk);
        chk({31'h0, power.thermistorBlockOn}, 32'h0);
        bus(1'b1, CSS_ADDR_CONTROL_ONE, 32'h13);
        repeat (10) @(posedge mclk);
        st(11'h010);
        chk({29'h0, power.converterOn, power.currentSelect}, 32'h6);
        done("fault");
        {s.batAboveSafe, s.batAboveSwitch, s.hostPowerMode} = 3'h1;
        apply();
        bus(1'b1, CSS_ADDR_CONTROL_ONE, 32'h4);
        repeat (80) @(posedge mclk);
        rd(CSS_ADDR_CONTROL_ONE, 32'h13);
        rd(CSS_ADDR_BAT_CURRENT, 32'h0);
        st(11'h008);
        chk({29'h0, power.linearSourceOn, power.currentSelect}, 32'h5);
        chk({31'h0, swPres}, 32'h1);
        s.batAboveSafe = 1'b1;
        apply();
        st(11'h010);
        s.batAbovePre = 1'b1;
        apply();
        st(11'h020);
        done("stack reset");
        fitted <= 1'b0;
        s.inAboveDetect = 1'b0;
        apply();
        st(11'h001);
        {s.inAboveDetect, s.inAboveBatMargin} = 2'h2;
        apply();
        st(11'h001);
        s.inAboveBatMargin = 1'b1;
        apply();
        repeat (80) @(posedge mclk);
        chk({31'h0, swPres}, 32'h0);
        done("replug");
        repeat (WD + 100) @(posedge mclk);
        bus(1'b0, CSS_ADDR_STATUS, 32'h0);
        chk({20'h0, q[14], q[10:0]}, 32'h880);
        bus(1'b1, CSS_ADDR_CONTROL_ONE, 32'h1b);
        repeat (10) @(posedge mclk);
        bus(1'b0, CSS_ADDR_STATUS, 32'h0);
        chk({31'h0, q[14]}, 32'h0);
        chk({31'h0, power.switchThresholdSelect}, 32'h1);
        done("watchdog");
        report_and_stop();
    end
endmodule
